// *** shared/i2c_wait_consts.svh ***
// timing counts and reset values for the wait and acknowledge control
`ifndef I2C_WAIT_CONSTS_SVH
`define I2C_WAIT_CONSTS_SVH
`define WAIT_ACK_CLOCK_NUM   4'h9
`define WAIT_DATA_LAST_NUM   4'h8
`define WAIT_BYTE_BITS       4'h8
`define WAIT_SEL_RESET       1'b0
`define WAIT_ACK_DRIVE_ENABLE_RESET     1'b0
`define WAIT_HOLD_CYCLES     8'h04
`endif

// *** shared/i2c_wait_pkg.sv ***
// types for the wait and acknowledge control
package i2c_wait_pkg;
    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_ADDR = 2'b01,
        PH_DATA = 2'b10,
        PH_EXT  = 2'b11
    } phase_t;
    typedef enum logic [1:0] {
        WS_RUN  = 2'b00,
        WS_WAIT = 2'b01,
        WS_HOLD = 2'b10
    } wait_state_t;
endpackage

// *** src/i2c_wait_irq_ack_control.sv ***
// wait insertion, transfer interrupt and acknowledge drive for an i2c unit
`timescale 1ns/1ps
`default_nettype none
`include "i2c_wait_consts.svh"
module i2c_wait_irq_ack_control (
    // clock and reset
    input  wire logic mclk,
    input  wire logic srst,
    // software control
    input  wire logic unit_operation_enable,
    input  wire logic waitIrqTimingSelectWr,
    input  wire logic waitIrqTimingSelectIn,
    input  wire logic ackDriveEnableWr,
    input  wire logic ackDriveEnableIn,
    input  wire logic wait_release_trigger,
    input  wire logic commExit,
    // transfer context from the rest of the unit
    input  wire logic masterMode,
    input  wire logic startSeen,
    input  wire logic stopSeen,
    input  wire logic addrMatch,
    input  wire logic extCode,
    // bus lines
    input  wire logic serialClockLineIn,
    input  wire logic serialDataLineIn,
    output logic      serialClockLineOut,
    output logic      serialClockLineOe,
    output logic      serialDataLineOut,
    output logic      serialDataLineOe,
    // status towards software
    output logic      transferIrq,
    output logic      waitActive,
    output logic      wait_irq_timing_select,
    output logic      ack_drive_enable,
    output logic      releasePending,
    output logic      statusClear,
    output logic [1:0] phaseOut
);
    import i2c_wait_pkg::*;

    logic        sclLevel;
    logic        sclRise;
    logic        sclFall;
    logic [3:0]  clkCount_ff;
    phase_t      phase_ff;
    wait_state_t wstate_ff;
    logic        wtim_ff;
    logic        ack_drive_enable_ff;
    logic        release_ff;
    logic        ackOn_ff;
    logic        irq_ff;
    logic        sclLow_ff;
    logic        statusClr_ff;
    logic        extByte_ff;
    logic [3:0]  irqEdge;
    logic [3:0]  waitEdge;
    logic        doAck;
    logic        ninthFall;
    logic        active;

    // ************************************************
    // line conditioning
    // ************************************************
    // pin is asynchronous: a fall is seen two edges after it happens
    line_sync sclSync (
        .mclk   (mclk),
        .srst   (srst),
        .lineIn (serialClockLineIn),
        .level  (sclLevel),
        .rise   (sclRise),
        .fall   (sclFall)
    );
    // data line is released except for acknowledge, so only its pin is observed elsewhere
    logic unusedSda;
    assign unusedSda = serialDataLineIn;

    // exit clears wait and ack like a disable, but the control bits survive
    assign active = unit_operation_enable & ~commExit;

    // ************************************************
    // software control bits
    // ************************************************
    // writes accepted only while disabled; ignored otherwise
    always_ff @(posedge mclk) begin
        if (srst) begin
            wtim_ff  <= `WAIT_SEL_RESET;
            ack_drive_enable_ff <= `WAIT_ACK_DRIVE_ENABLE_RESET;
        end else if (!unit_operation_enable) begin
            if (waitIrqTimingSelectWr)
                wtim_ff <= waitIrqTimingSelectIn;
            if (ackDriveEnableWr)
                ack_drive_enable_ff <= ackDriveEnableIn;
        end
    end

    // ************************************************
    // byte phase and clock counting
    // ************************************************
    always_ff @(posedge mclk) begin
        if (srst || !active) begin
            phase_ff    <= PH_IDLE;
            clkCount_ff <= 4'h0;
        end else if (startSeen) begin
            phase_ff    <= PH_ADDR;
            clkCount_ff <= 4'h0;
        end else if (stopSeen) begin
            phase_ff    <= PH_IDLE;
            clkCount_ff <= 4'h0;
        end else if (sclFall && phase_ff != PH_IDLE) begin
            // an unmatched slave counts on to the ninth edge too; no standby here
            if (clkCount_ff == `WAIT_ACK_CLOCK_NUM - 4'h1) begin
                clkCount_ff <= 4'h0;
                if (phase_ff == PH_ADDR)
                    phase_ff <= PH_DATA;
            end else begin
                clkCount_ff <= clkCount_ff + 4'h1;
                if (phase_ff == PH_ADDR && !masterMode && extCode
                    && clkCount_ff == `WAIT_BYTE_BITS - 4'h1)
                    phase_ff <= PH_EXT;
            end
        end
    end

    // ************************************************
    // interrupt and wait positions
    // ************************************************
    // edge number (1-based) at which the interrupt and the wait fall
    always_comb begin
        irqEdge  = wtim_ff ? `WAIT_ACK_CLOCK_NUM : `WAIT_DATA_LAST_NUM;
        waitEdge = irqEdge;
        if (phase_ff == PH_ADDR) begin
            irqEdge  = `WAIT_ACK_CLOCK_NUM;
            waitEdge = `WAIT_ACK_CLOCK_NUM;
        end else if (extByte_ff) begin
            // extension byte waits once, at its eighth edge
            irqEdge  = `WAIT_DATA_LAST_NUM;
            waitEdge = `WAIT_DATA_LAST_NUM;
        end
    end

    assign ninthFall = sclFall && clkCount_ff == `WAIT_ACK_CLOCK_NUM - 4'h1;

    // extension byte enters PH_EXT on its eighth edge; catch that edge too
    logic extEighth;
    assign extEighth = sclFall && phase_ff == PH_ADDR && !masterMode && extCode
                       && clkCount_ff == `WAIT_BYTE_BITS - 4'h1;

    logic edgeHit;
    assign edgeHit = sclFall && phase_ff != PH_IDLE
                     && (clkCount_ff + 4'h1 == waitEdge);

    // ************************************************
    // extension byte marker
    // ************************************************
    // lives from the eighth edge of an extension code to its ninth;
    // later bytes of the frame fall back to the select bit
    // start and stop drop it too, in case a frame is cut short
    always_ff @(posedge mclk) begin
        if (srst || !active)
            extByte_ff <= 1'b0;
        else if (startSeen || stopSeen)
            extByte_ff <= 1'b0;
        else if (extEighth)
            extByte_ff <= 1'b1;
        else if (ninthFall)
            extByte_ff <= 1'b0;
    end

    // ************************************************
    // wait state machine
    // ************************************************
    always_ff @(posedge mclk) begin
        if (srst || !active) begin
            wstate_ff <= WS_RUN;
            irq_ff    <= 1'b0;
            sclLow_ff <= 1'b0;
        end else begin
            // hold and interrupt start together, so the irq never meets a free line
            irq_ff <= edgeHit || extEighth;
            unique case (wstate_ff)
                WS_RUN: begin
                    if ((edgeHit && !extEighth) || extEighth) begin
                        wstate_ff <= WS_WAIT;
                        sclLow_ff <= 1'b1;
                    end
                end
                WS_WAIT: begin
                    // consuming the release here is what self-clears the trigger
                    if (release_ff) begin
                        wstate_ff <= WS_HOLD;
                        sclLow_ff <= 1'b0;
                    end else begin
                        sclLow_ff <= 1'b1;
                    end
                end
                WS_HOLD: begin
                    // wait for line to rise before counting again
                    if (sclLevel)
                        wstate_ff <= WS_RUN;
                end
                default: wstate_ff <= WS_RUN;
            endcase
        end
    end

    // release trigger holds until the wait it targets is gone
    // limitation: a release written outside a wait ends the next one at once
    always_ff @(posedge mclk) begin
        if (srst || !active)
            release_ff <= 1'b0;
        else if (wstate_ff == WS_WAIT && release_ff)
            release_ff <= 1'b0;
        else if (wait_release_trigger)
            release_ff <= 1'b1;
    end

    // ************************************************
    // acknowledge drive
    // ************************************************
    // address: matched slave always acks; ext byte: ack enable decides
    always_comb begin
        doAck = 1'b0;
        if (!masterMode && phase_ff == PH_ADDR && addrMatch)
            doAck = 1'b1;
        else if (phase_ff == PH_ADDR && !masterMode && extCode)
            doAck = ack_drive_enable_ff;
        else if (phase_ff == PH_EXT || phase_ff == PH_DATA)
            doAck = ack_drive_enable_ff;
    end

    // drive spans the ninth clock: from the eighth fall to the ninth
    always_ff @(posedge mclk) begin
        if (srst || !active)
            ackOn_ff <= 1'b0;
        else if (sclFall && clkCount_ff == `WAIT_BYTE_BITS - 4'h1)
            ackOn_ff <= doAck;
        else if (ninthFall || startSeen || stopSeen)
            ackOn_ff <= 1'b0;
    end

    // status reset level, held high for as long as the unit is disabled
    // reset value 1: status reads cleared until the first enable
    always_ff @(posedge mclk) begin
        if (srst)
            statusClr_ff <= 1'b1;
        else
            statusClr_ff <= ~unit_operation_enable;
    end

    // ************************************************
    // registered outputs
    // ************************************************
    always_ff @(posedge mclk) begin
        if (srst) begin
            serialClockLineOut     <= 1'b0;
            serialClockLineOe      <= 1'b0;
            serialDataLineOut      <= 1'b0;
            serialDataLineOe       <= 1'b0;
            transferIrq            <= 1'b0;
            waitActive             <= 1'b0;
            wait_irq_timing_select <= `WAIT_SEL_RESET;
            ack_drive_enable       <= `WAIT_ACK_DRIVE_ENABLE_RESET;
            releasePending         <= 1'b0;
            statusClear            <= 1'b1;
            phaseOut               <= 2'h0;
        end else begin
            // open drain: out values stay 0, only the enables move
            serialClockLineOut     <= 1'b0;
            serialClockLineOe      <= sclLow_ff;
            serialDataLineOut      <= 1'b0;
            serialDataLineOe       <= ackOn_ff;
            transferIrq            <= irq_ff;
            waitActive             <= sclLow_ff;
            wait_irq_timing_select <= wtim_ff;
            ack_drive_enable       <= ack_drive_enable_ff;
            releasePending         <= release_ff;
            statusClear            <= statusClr_ff;
            phaseOut               <= phase_ff;
        end
    end
endmodule
`default_nettype wire

// *** src/line_sync.sv ***
// two-flop synchroniser with edge detection for a bus line
`timescale 1ns/1ps
`default_nettype none
module line_sync (
    // clock and reset
    input  wire logic mclk,
    input  wire logic srst,
    // line
    input  wire logic lineIn,
    // conditioned outputs
    output logic      level,
    output logic      rise,
    output logic      fall
);
    logic meta_ff;
    logic sync_ff;
    logic last_ff;

    // ************************************************
    // synchroniser: meta_ff feeds sync_ff only
    // ************************************************
    always_ff @(posedge mclk) begin
        if (srst) begin
            meta_ff <= 1'b1;
            sync_ff <= 1'b1;
            last_ff <= 1'b1;
        end else begin
            meta_ff <= lineIn;
            sync_ff <= meta_ff;
            last_ff <= sync_ff;
        end
    end

    assign level = sync_ff;
    assign rise  = sync_ff & ~last_ff;
    assign fall  = ~sync_ff & last_ff;
endmodule
`default_nettype wire

// *** tb/i2c_bus_peer.sv ***
// far-side bus master model: clock pulses with stretching
`timescale 1ns/1ps
`default_nettype none
module i2c_bus_peer (
    // bus wires
    input  wire logic sclWire,
    input  wire logic sdaWire,
    output logic      sclDrv,
    output logic      sdaDrv
);
    int   fallCnt = 0;
    logic ackSeen = 1'b0;
    initial begin
        sclDrv = 1'b1;
        sdaDrv = 1'b1;
    end
    // long low phase so a hold lands before our release
    task automatic burst(input int n);
        fallCnt = 0;
        ackSeen = 1'b0;
        repeat (n) begin
            #30 sclDrv = 1'b0;
            fallCnt++;
            #130 sclDrv = 1'b1;
            wait (sclWire === 1'b1);
            if (fallCnt == 8) ackSeen = !sdaWire;
        end
    endtask
endmodule
`default_nettype wire

// *** tb/i2c_wait_asserts.sv ***
// concurrent checks on the wait, interrupt and acknowledge control ports
`timescale 1ns/1ps
`default_nettype none
module i2c_wait_asserts (
    // clock and reset
    input wire logic mclk,
    input wire logic srst,
    // watched ports
    input wire logic unit_operation_enable,
    input wire logic wait_release_trigger,
    input wire logic commExit,
    input wire logic transferIrq,
    input wire logic waitActive,
    input wire logic serialClockLineOe,
    input wire logic serialDataLineOe,
    input wire logic wait_irq_timing_select,
    input wire logic ack_drive_enable,
    input wire logic releasePending,
    input wire logic statusClear
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (srst);
    // ****************************************
    // assertions
    // ****************************************
    a_irq_one_pulse: assert property (transferIrq |=> !transferIrq)
        else $error("transfer interrupt longer than one cycle");
    a_irq_with_hold: assert property (transferIrq |-> serialClockLineOe && waitActive)
        else $error("interrupt without clock hold");
    // release latency is one cycle past the pending flag; the past term allows one cycle more
    a_hold_kept: assert property (serialClockLineOe && unit_operation_enable && !commExit
        && !releasePending && !$past(releasePending) |=> serialClockLineOe)
        else $error("clock hold dropped without release");
    a_release_ends: assert property (serialClockLineOe && wait_release_trigger
        |-> ##[1:4] !serialClockLineOe)
        else $error("release did not free the clock line");
    a_exit_drops: assert property (commExit && serialClockLineOe |-> ##[1:3] !serialClockLineOe)
        else $error("exit did not free the clock line");
    a_disabled_idle: assert property (!unit_operation_enable [*3]
        |-> !serialClockLineOe && !serialDataLineOe && !transferIrq && statusClear)
        else $error("disabled unit still active");
    a_sel_locked: assert property (unit_operation_enable |=> $stable(wait_irq_timing_select))
        else $error("select bit changed while enabled");
    a_ack_locked: assert property (unit_operation_enable |=> $stable(ack_drive_enable))
        else $error("ack enable changed while enabled");
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
// top-level testbench for the wait, interrupt and acknowledge control
`timescale 1ns/1ps
`default_nettype none
`include "i2c_wait_consts.svh"
module tb_top;
    logic       mclk, srst, unit_operation_enable, commExit, wait_release_trigger;
    logic       waitIrqTimingSelectWr, waitIrqTimingSelectIn, ackDriveEnableWr;
    logic       ackDriveEnableIn, masterMode, startSeen, stopSeen, addrMatch, extCode;
    logic       sclDrv, sdaDrv, serialClockLineOut, serialClockLineOe, serialDataLineOut;
    logic       serialDataLineOe, transferIrq, waitActive, wait_irq_timing_select;
    logic       ack_drive_enable, releasePending, statusClear;
    logic [1:0] phaseOut;
    logic [7:0] irqFall = 8'h00;
    logic [7:0] irqCnt = 8'h00;
    logic [31:0] rnd;
    int         errCount, checksDone;
    wire logic  serialClockLineIn = sclDrv & ~serialClockLineOe;
    wire logic  serialDataLineIn = sdaDrv & ~serialDataLineOe;
    i2c_bus_peer peer (.sclWire(serialClockLineIn), .sdaWire(serialDataLineIn), .sclDrv, .sdaDrv);
    i2c_wait_irq_ack_control dut (.mclk, .srst, .unit_operation_enable, .waitIrqTimingSelectWr,
        .waitIrqTimingSelectIn, .ackDriveEnableWr, .ackDriveEnableIn, .wait_release_trigger,
        .commExit, .masterMode, .startSeen, .stopSeen, .addrMatch, .extCode, .serialClockLineIn,
        .serialDataLineIn, .serialClockLineOut, .serialClockLineOe, .serialDataLineOut,
        .serialDataLineOe, .transferIrq, .waitActive, .wait_irq_timing_select,
        .ack_drive_enable, .releasePending, .statusClear, .phaseOut);
    // ****************************************
    // helpers and scenarios
    // ****************************************
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    always @(posedge mclk) if (transferIrq === 1'b1) begin
        irqFall <= peer.fallCnt[7:0];
        irqCnt <= irqCnt + 8'h01;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    function automatic logic [7:0] fallAt(input logic addr, input logic x, input logic s);
        return addr ? (x ? 8'h08 : 8'h09) : (s ? 8'h09 : 8'h08);
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #2;
    endtask
    task automatic chkBit(input string what, input logic exp, input logic got);
        checksDone++;
        if (got !== exp) begin
            errCount++;
            $display("unexpected %s exp %b got %b", what, exp, got);
        end
    endtask
    task automatic chkByte(input string what, input logic [7:0] exp, input logic [7:0] got);
        checksDone++;
        if (got !== exp) begin
            errCount++;
            $display("unexpected %s exp %0h got %0h", what, exp, got);
        end
    endtask
    task automatic waitHold();
        for (int k = 0; k < 400 && waitActive !== 1'b1; k++) tick(1);
    endtask
    task automatic cfg(input logic s, input logic a);
        unit_operation_enable = 1'b0;
        tick(2);
        {waitIrqTimingSelectWr, waitIrqTimingSelectIn, ackDriveEnableWr} = {1'b1, s, 1'b1};
        ackDriveEnableIn = a;
        tick(1);
        {waitIrqTimingSelectWr, ackDriveEnableWr} = 2'h0;
        tick(1);
        chkBit("statClr", 1'b1, statusClear);
    endtask
    task automatic slot(input logic [7:0] fall, input logic ack);
        logic [7:0] irqBase;
        irqBase = irqCnt;
        fork
            peer.burst(9);
            begin
                waitHold();
                tick(1);
                chkByte("irqFall", fall, irqFall);
                tick(5);
                chkBit("sclHeld", 1'b0, serialClockLineIn);
                wait_release_trigger = 1'b1;
                tick(1);
                wait_release_trigger = 1'b0;
            end
        join
        tick(4);
        chkByte("irqCnt", irqBase + 8'h01, irqCnt);
        chkBit("ack", ack, peer.ackSeen);
    endtask
    task automatic frame(input logic m, mt, x, s, a);
        cfg(s, a);
        {masterMode, addrMatch, extCode, unit_operation_enable} = {m, mt, x, 1'b1};
        tick(2);
        {waitIrqTimingSelectWr, waitIrqTimingSelectIn} = {1'b1, ~s};
        tick(1);
        {waitIrqTimingSelectWr, startSeen} = 2'h1;
        tick(1);
        startSeen = 1'b0;
        chkBit("selLock", s, wait_irq_timing_select);
        chkBit("ackBit", a, ack_drive_enable);
        slot(fallAt(1'b1, x, s), x ? a : (!m && mt));
        slot(fallAt(1'b0, x, s), a);
        stopSeen = 1'b1;
        tick(1);
        stopSeen = 1'b0;
    endtask
    task final_report();
        $display("errors %0d checks %0d", errCount, checksDone);
        if (errCount == 0 && checksDone > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        {srst, unit_operation_enable, commExit, wait_release_trigger, masterMode} = 5'h10;
        {waitIrqTimingSelectWr, waitIrqTimingSelectIn, ackDriveEnableWr, ackDriveEnableIn} = 4'h0;
        {startSeen, stopSeen, addrMatch, extCode} = 4'h0;
        errCount = 0;
        checksDone = 0;
        rnd = 32'h0001541C;
        repeat (12) @(posedge mclk);
        #2 srst = 1'b0;
        tick(2);
        chkBit("selRst", `WAIT_SEL_RESET, wait_irq_timing_select);
        chkBit("ackRst", `WAIT_ACK_DRIVE_ENABLE_RESET, ack_drive_enable);
        frame(1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
        frame(1'b0, 1'b1, 1'b0, 1'b1, 1'b0);
        frame(1'b0, 1'b0, 1'b1, 1'b1, 1'b1);
        frame(1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
        for (int i = 0; i < 6; i++) begin
            rnd = lfsr(rnd);
            frame(rnd[0], rnd[0] | ~rnd[1], ~rnd[0] & rnd[1], rnd[2], rnd[3]);
        end
        cfg(1'b1, 1'b0);
        {unit_operation_enable, startSeen} = 2'h3;
        tick(1);
        startSeen = 1'b0;
        fork
            peer.burst(9);
            begin
                waitHold();
                commExit = 1'b1;
                tick(4);
                chkBit("exitRel", 1'b0, serialClockLineOe);
                commExit = 1'b0;
            end
        join
        final_report();
    end
    // generous bound: a full run needs a few thousand cycles
    initial begin
        repeat (40000) @(posedge mclk);
        errCount++;
        final_report();
    end
endmodule
bind i2c_wait_irq_ack_control i2c_wait_asserts chk (.mclk, .srst, .unit_operation_enable,
    .wait_release_trigger, .commExit, .transferIrq, .waitActive, .serialClockLineOe,
    .serialDataLineOe, .wait_irq_timing_select, .ack_drive_enable, .releasePending, .statusClear);
`default_nettype wire
